// ==== shared/accel_ctrl_pkg.sv ====
package accel_ctrl_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] X_SAMPLE_OFS = 8'h00;
   localparam logic [7:0] Y_SAMPLE_OFS = 8'h01;
   localparam logic [7:0] Z_SAMPLE_OFS = 8'h02;
   localparam logic [7:0] STATUS_OFS = 8'h03;
   localparam logic [7:0] INTERRUPT_SETUP_OFS = 8'h06;
   localparam logic [7:0] MODE_CONTROL_OFS = 8'h07;
   localparam logic [7:0] SAMPLE_RATE_CONFIG_OFS = 8'h08;
   localparam logic [7:0] SLEEP_COUNT_OFS = 8'h05;

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int MODE_ACTIVE_BIT = 0;
   localparam int MODE_TEST_BIT = 2;
   localparam int MODE_AUTO_WAKE_BIT = 3;
   localparam int MODE_AUTO_SLEEP_BIT = 4;
   localparam int RATE_SLEEP_LSB = 3;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int SAMPLE_W = 6;

   // Sample interval times in microseconds, as printed
   localparam int CLK_MHZ = 100;
   localparam int T_120_US = 8360;
   localparam int T_64_US = 15625;
   localparam int T_32_US = 31250;
   localparam int T_16_US = 62500;
   localparam int T_8_US = 125000;
   localparam int T_4_US = 250000;
   localparam int T_2_US = 500000;
   localparam int T_1_US = 1000000;
   localparam int CNT_W = 27;

   typedef enum logic [1:0]
   {
      MODE_OFF = 2'b00,
      MODE_STANDBY = 2'b01,
      MODE_ACTIVE = 2'b10,
      MODE_TEST = 2'b11
   } power_mode_t;

   // Interrupt enable fields
   typedef struct packed
   {
      logic shake_z_irq_en;
      logic shake_y_irq_en;
      logic shake_x_irq_en;
      logic data_update_irq_en;
      logic auto_sleep_irq_en;
      logic tap_irq_en;
      logic portrait_landscape_irq_en;
      logic front_back_irq_en;
   } irq_setup_t;

   // Register access from the serial slave
   typedef struct packed
   {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;
endpackage : accel_ctrl_pkg

// ==== verilog/accel_mode_rate_irq_control.sv ====
`timescale 1ns/10ps
// Function
// - Exactly one power mode at a time
// - Off mode ignores all register traffic
// - Supplies up: Standby, registers usable, idle
// - Host mode bit picks Standby or Active
// - Active: measure continuously, run enabled analysis
// - Eight wake rates via sample-rate register
// - Sleep rate only 32,16,8,1 per second
// - Each interval updates three 6-bit samples
// - Interrupt setup holds individual enables
// - Data-update interrupt after every sample update
// - Enabled axis shake over 1.3g interrupts
// - Orientation change interrupts when enabled
// - Sleep counter expiry interrupts with auto-wake
// - Motion events return sleep to wake
// - Auto-wake/sleep switches high and low rates
// - Tap active except in auto-wake state
// - Test mode: host writes axis samples
// - Test samples analysed like real ones
// - No measurements in Standby or Test
// - X, Y, Z samples at 0x00-0x02
// - 3-bit rate field selects interval
// - Distinct enable gates each interrupt cause
module accel_mode_rate_irq_control
   import accel_ctrl_pkg::*;
(
   input wire logic sys_clk_in, // 100 MHz clock
   input wire logic sys_rst_in, // Sync reset, active high
   input wire logic avdd_ok_in, // Analog supply present (pin)
   input wire reg_req_t req_in, // Register request
   output logic req_ack_out, // Request accepted
   output logic [7:0] rdata_out, // Read data
   input wire logic [5:0] meas_x_in, // Converter X result
   input wire logic [5:0] meas_y_in, // Converter Y result
   input wire logic [5:0] meas_z_in, // Converter Z result
   input wire logic shake_x_in, // X over 1.3 g
   input wire logic shake_y_in, // Y over 1.3 g
   input wire logic shake_z_in, // Z over 1.3 g
   input wire logic tap_in, // Tap or delta-G seen
   input wire logic [4:0] orient_in, // Detected orientation code
   output logic meas_start_out, // Start a conversion
   output power_mode_t mode_out, // Present power mode
   output logic asleep_out, // In auto-sleep state
   output logic irq_out // Interrupt, active high
);

   // ------------------------------------------------------------
   // Supply synchroniser
   // ------------------------------------------------------------
   logic avdd_meta_r;
   logic avdd_r;
   // Two stages: the supply pin is not timed to this clock
   always_ff @(posedge sys_clk_in)
   begin
      avdd_meta_r <= avdd_ok_in;
      avdd_r <= avdd_meta_r;
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   irq_setup_t irq_setup_r;
   logic [7:0] mode_control_r;
   logic [7:0] sample_rate_config_r;
   logic [7:0] sleep_count_r;
   logic [5:0] x_sample_reg_r;
   logic [5:0] y_sample_reg_r;
   logic [5:0] z_sample_reg_r;
   logic [4:0] orient_r;
   logic asleep_r;
   logic [7:0] idle_cnt_r;
   logic [CNT_W-1:0] tick_cnt_r;
   // Causes: data, shake, tap, orient, sleep, spare
   logic [5:0] pend_r;
   logic [5:0] pend_set;
   logic tick;

   // Off mode gates every access away
   wire access_ok = avdd_r;
   wire wr = req_in.wr && access_ok;
   wire rd = req_in.rd && access_ok;
   // Test bit overrides the active bit
   wire test_mode = mode_control_r[MODE_TEST_BIT];
   wire active_mode = mode_control_r[MODE_ACTIVE_BIT] && !test_mode;
   wire auto_wake = mode_control_r[MODE_AUTO_WAKE_BIT];
   wire auto_sleep = mode_control_r[MODE_AUTO_SLEEP_BIT];

   // One mode only; priority Off, Test, Active, Standby
   assign mode_out = !avdd_r ? MODE_OFF :
                     test_mode ? MODE_TEST :
                     active_mode ? MODE_ACTIVE : MODE_STANDBY;
   // No wait states: with the supply up, every request is taken in its own cycle
   assign req_ack_out = wr || rd;
   assign asleep_out = asleep_r;

   // ------------------------------------------------------------
   // Rate selection
   // ------------------------------------------------------------
   function automatic logic [CNT_W-1:0] wake_cycles(input logic [2:0] s);
      case (s)
         3'h0: wake_cycles = CNT_W'(T_120_US * CLK_MHZ);
         3'h1: wake_cycles = CNT_W'(T_64_US * CLK_MHZ);
         3'h2: wake_cycles = CNT_W'(T_32_US * CLK_MHZ);
         3'h3: wake_cycles = CNT_W'(T_16_US * CLK_MHZ);
         3'h4: wake_cycles = CNT_W'(T_8_US * CLK_MHZ);
         3'h5: wake_cycles = CNT_W'(T_4_US * CLK_MHZ);
         3'h6: wake_cycles = CNT_W'(T_2_US * CLK_MHZ);
         default: wake_cycles = CNT_W'(T_1_US * CLK_MHZ);
      endcase
   endfunction : wake_cycles

   // Sleep offers only four slow rates
   function automatic logic [CNT_W-1:0] sleep_cycles(input logic [1:0] s);
      case (s)
         2'h0: sleep_cycles = CNT_W'(T_32_US * CLK_MHZ);
         2'h1: sleep_cycles = CNT_W'(T_16_US * CLK_MHZ);
         2'h2: sleep_cycles = CNT_W'(T_8_US * CLK_MHZ);
         default: sleep_cycles = CNT_W'(T_1_US * CLK_MHZ);
      endcase
   endfunction : sleep_cycles

   // Wake rate from the 3-bit field, sleep rate when asleep
   wire [2:0] active_rate_select = sample_rate_config_r[2:0];
   wire [1:0] sleep_sel = sample_rate_config_r[RATE_SLEEP_LSB +: 2];
   wire [CNT_W-1:0] reload = asleep_r ? sleep_cycles(sleep_sel)
                                      : wake_cycles(active_rate_select);

   // Interval counter; idle in Standby and
   // Parks at zero outside Active, so entry samples at once
   assign tick = active_mode && avdd_r && (tick_cnt_r == '0);
   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in || !active_mode || !avdd_r)
         tick_cnt_r <= '0;
      else if (tick_cnt_r == '0)
         tick_cnt_r <= reload - CNT_W'(1);
      else
         tick_cnt_r <= tick_cnt_r - CNT_W'(1);
   end
   assign meas_start_out = tick;

   // ------------------------------------------------------------
   // Analysis events
   // ------------------------------------------------------------
   // Test writes feed analysis as a fresh sample
   wire test_wr = wr && test_mode && (req_in.addr <= Z_SAMPLE_OFS);
   wire sample_evt = tick || test_wr;
   wire shake_any = (shake_x_in && irq_setup_r.shake_x_irq_en) ||
                    (shake_y_in && irq_setup_r.shake_y_irq_en) ||
                    (shake_z_in && irq_setup_r.shake_z_irq_en);
   // Tap ignored while in the auto-wake state
   wire tap_ok = tap_in && irq_setup_r.tap_irq_en &&
                 !(auto_wake && !asleep_r);
   wire orient_en = irq_setup_r.front_back_irq_en ||
                    irq_setup_r.portrait_landscape_irq_en;
   wire orient_chg = orient_en && (orient_in != orient_r);
   wire sleep_expire = auto_sleep && !asleep_r &&
                       (idle_cnt_r == sleep_count_r);
   wire motion = shake_any || tap_ok || orient_chg;

   // Cause vector gated by its own enable
   assign pend_set = {
      sample_evt && irq_setup_r.data_update_irq_en,
      sample_evt && shake_any,
      sample_evt && tap_ok,
      sample_evt && orient_chg,
      sample_evt && sleep_expire && auto_wake &&
         irq_setup_r.auto_sleep_irq_en,
      1'b0};

   // Sleep state and inactivity count
   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in || !active_mode)
      begin
         asleep_r <= 1'b0;
         idle_cnt_r <= '0;
      end
      else if (sample_evt)
      begin
         if (motion)
         begin
            asleep_r <= 1'b0;
            idle_cnt_r <= '0;
         end
         else if (sleep_expire)
            asleep_r <= 1'b1;
         else if (!asleep_r)
            idle_cnt_r <= idle_cnt_r + 8'h01;
      end
   end

   // Orientation reference follows each sample
   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
         orient_r <= '0;
      else if (sample_evt)
         orient_r <= orient_in;
   end

   // Pending causes; set wins over a read clear
   // The read itself is the clear; no separate acknowledge exists
   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
         pend_r <= '0;
      else if (rd && req_in.addr == STATUS_OFS)
         pend_r <= pend_set;
      else
         pend_r <= pend_r | pend_set;
   end
   assign irq_out = |pend_r;

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
      begin
         irq_setup_r <= irq_setup_t'(REG_RESET);
         mode_control_r <= REG_RESET;
         sample_rate_config_r <= REG_RESET;
         sleep_count_r <= REG_RESET;
      end
      else if (wr)
      begin
         if (req_in.addr == INTERRUPT_SETUP_OFS)
            irq_setup_r <= irq_setup_t'(req_in.wdata);
         else if (req_in.addr == MODE_CONTROL_OFS)
            mode_control_r <= req_in.wdata;
         else if (req_in.addr == SAMPLE_RATE_CONFIG_OFS)
            sample_rate_config_r <= req_in.wdata;
         else if (req_in.addr == SLEEP_COUNT_OFS)
            sleep_count_r <= req_in.wdata;
      end
   end

   // Samples: measured in Active, host-written in
   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
      begin
         x_sample_reg_r <= '0;
         y_sample_reg_r <= '0;
         z_sample_reg_r <= '0;
      end
      else if (tick)
      begin
         x_sample_reg_r <= meas_x_in;
         y_sample_reg_r <= meas_y_in;
         z_sample_reg_r <= meas_z_in;
      end
      else if (test_wr)
      begin
         if (req_in.addr == X_SAMPLE_OFS)
            x_sample_reg_r <= req_in.wdata[5:0];
         else if (req_in.addr == Y_SAMPLE_OFS)
            y_sample_reg_r <= req_in.wdata[5:0];
         else
            z_sample_reg_r <= req_in.wdata[5:0];
      end
   end

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   // Unmapped offsets read as zero
   logic [7:0] rdata_nxt;
   always_comb
   begin
      if (req_in.addr == X_SAMPLE_OFS)
         rdata_nxt = {2'b00, x_sample_reg_r};
      else if (req_in.addr == Y_SAMPLE_OFS)
         rdata_nxt = {2'b00, y_sample_reg_r};
      else if (req_in.addr == Z_SAMPLE_OFS)
         rdata_nxt = {2'b00, z_sample_reg_r};
      else if (req_in.addr == STATUS_OFS)
         rdata_nxt = {asleep_r, 1'b0, pend_r};
      else if (req_in.addr == SLEEP_COUNT_OFS)
         rdata_nxt = sleep_count_r;
      else if (req_in.addr == INTERRUPT_SETUP_OFS)
         rdata_nxt = irq_setup_r;
      else if (req_in.addr == MODE_CONTROL_OFS)
         rdata_nxt = mode_control_r;
      else if (req_in.addr == SAMPLE_RATE_CONFIG_OFS)
         rdata_nxt = sample_rate_config_r;
      else
         rdata_nxt = 8'h00;
   end

   // Registered read data, held between reads
   // Holding it lets a slow host fetch a status that was just cleared
   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
         rdata_out <= 8'h00;
      else if (rd)
         rdata_out <= rdata_nxt;
   end
endmodule : accel_mode_rate_irq_control

// ==== test/accel_ctrl_props.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// Port checker for mode and register access
// ------------------------------------------------------------
module accel_ctrl_props
   import accel_ctrl_pkg::*;
(
   input wire logic sys_clk_in, // Clock
   input wire logic sys_rst_in, // Sync reset
   input wire reg_req_t req_in, // Register request
   input wire logic req_ack_out, // Request taken
   input wire logic [7:0] rdata_out, // Read data
   input wire logic meas_start_out, // Conversion start
   input wire power_mode_t mode_out // Power mode
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (sys_rst_in);

   // Accepted write to the mode register
   sequence mode_wr_s;
      req_ack_out && req_in.wr && req_in.addr == MODE_CONTROL_OFS;
   endsequence

   off_no_ack_a: assert property (mode_out == MODE_OFF |-> !req_ack_out)
      else $error("Request taken while off");
   ack_cause_a: assert property (req_ack_out |-> req_in.wr || req_in.rd)
      else $error("Ack without request");
   ack_when_up_a:
      assert property (mode_out != MODE_OFF && (req_in.wr || req_in.rd)
         |-> req_ack_out)
      else $error("Request refused with supply up");
   stby_idle_a:
      assert property (mode_out == MODE_STANDBY |-> !meas_start_out)
      else $error("Conversion in standby");
   test_idle_a:
      assert property (mode_out == MODE_TEST |-> !meas_start_out)
      else $error("Conversion in test mode");
   start_mode_a:
      assert property (meas_start_out |-> mode_out == MODE_ACTIVE)
      else $error("Conversion outside active");
   start_pulse_a: assert property (meas_start_out |=> !meas_start_out)
      else $error("Start longer than one cycle");
   active_wr_a:
      assert property (mode_wr_s ##0 req_in.wdata[2:0] == 3'h1
         |=> mode_out inside {MODE_ACTIVE, MODE_OFF})
      else $error("Active bit not obeyed");
   stby_wr_a:
      assert property (mode_wr_s ##0 req_in.wdata[2:0] == 3'h0
         |=> mode_out inside {MODE_STANDBY, MODE_OFF})
      else $error("Standby not obeyed");
   test_wr_a:
      assert property (mode_wr_s ##0 req_in.wdata[MODE_TEST_BIT]
         |=> mode_out inside {MODE_TEST, MODE_OFF})
      else $error("Test bit not obeyed");
   rdata_hold_a:
      assert property (!(req_ack_out && req_in.rd) |=> $stable(rdata_out))
      else $error("Read data moved without read");
endmodule : accel_ctrl_props

bind accel_mode_rate_irq_control accel_ctrl_props u_props (
   .sys_clk_in(sys_clk_in),
   .sys_rst_in(sys_rst_in),
   .req_in(req_in),
   .req_ack_out(req_ack_out),
   .rdata_out(rdata_out),
   .meas_start_out(meas_start_out),
   .mode_out(mode_out)
);

// ==== test/host_model.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// Serial host side: one-cycle register requests
// ------------------------------------------------------------
module host_model
   import accel_ctrl_pkg::*;
(
   input wire logic sys_clk_in, // Clock
   input wire logic ack_in, // Request taken
   input wire logic [7:0] rdata_in, // Read data
   output reg_req_t req_out // Register request
);
   initial req_out = '0;

   // Idle fields carry the inverse, so stale values never look valid
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [7:0] d, output logic ack, output logic [7:0] q);
      @(posedge sys_clk_in);
      req_out <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge sys_clk_in);
      ack = ack_in;
      req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      @(posedge sys_clk_in);
      q = rdata_in;
   endtask : xfer
endmodule : host_model

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// Register-level bench
// ------------------------------------------------------------
module tb_top;
   import accel_ctrl_pkg::*;
   logic sys_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic avdd_ok_in = 1'b0;
   reg_req_t req;
   logic ack;
   logic [7:0] rdata;
   logic [5:0] mx = 6'h11, my = 6'h22, mz = 6'h33;
   logic shx = 1'b0, shy = 1'b0, shz = 1'b0, tap = 1'b0;
   logic [4:0] orient = 5'h01;
   logic meas_start, asleep, irq;
   power_mode_t mode;
   int error_cnt = 0;
   int num_checks = 0;
   logic a;
   logic [7:0] q;

   always #5 sys_clk_in = ~sys_clk_in;

   accel_mode_rate_irq_control u_dut (.sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in), .avdd_ok_in(avdd_ok_in), .req_in(req),
      .req_ack_out(ack), .rdata_out(rdata), .meas_x_in(mx),
      .meas_y_in(my), .meas_z_in(mz), .shake_x_in(shx), .shake_y_in(shy),
      .shake_z_in(shz), .tap_in(tap), .orient_in(orient),
      .meas_start_out(meas_start), .mode_out(mode), .asleep_out(asleep),
      .irq_out(irq));

   host_model u_host (.sys_clk_in(sys_clk_in), .ack_in(ack),
      .rdata_in(rdata), .req_out(req));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask : cyc

   task automatic end_sim;
      $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   // Watchdog: the whole sequence needs well under 20000 cycles
   initial
   begin
      cyc(20000);
      error_cnt++;
      end_sim();
   end

   // Main sequence
   initial
   begin
      cyc(20);
      sys_rst_in <= 1'b0;
      cyc(2);
      u_host.xfer(1'b0, MODE_CONTROL_OFS, 8'h00, a, q);
      check({7'h00, a}, 8'h00);
      check({6'h00, mode}, {6'h00, MODE_OFF});
      $display("off mode done");
      avdd_ok_in <= 1'b1;
      cyc(5);
      check({6'h00, mode}, {6'h00, MODE_STANDBY});
      u_host.xfer(1'b0, INTERRUPT_SETUP_OFS, 8'h00, a, q);
      check(q, REG_RESET);
      u_host.xfer(1'b0, SAMPLE_RATE_CONFIG_OFS, 8'h00, a, q);
      check(q, REG_RESET);
      u_host.xfer(1'b1, INTERRUPT_SETUP_OFS, 8'h10, a, q);
      u_host.xfer(1'b1, SAMPLE_RATE_CONFIG_OFS, 8'h1D, a, q);
      u_host.xfer(1'b0, INTERRUPT_SETUP_OFS, 8'h00, a, q);
      check(q, 8'h10);
      u_host.xfer(1'b0, SAMPLE_RATE_CONFIG_OFS, 8'h00, a, q);
      check(q, 8'h1D);
      u_host.xfer(1'b0, 8'h04, 8'h00, a, q);
      check(q, 8'h00);
      $display("register access done");
      u_host.xfer(1'b1, MODE_CONTROL_OFS, 8'h04, a, q);
      check({6'h00, mode}, {6'h00, MODE_TEST});
      u_host.xfer(1'b1, X_SAMPLE_OFS, 8'h2A, a, q);
      u_host.xfer(1'b1, Y_SAMPLE_OFS, 8'h15, a, q);
      u_host.xfer(1'b1, Z_SAMPLE_OFS, 8'h3F, a, q);
      u_host.xfer(1'b0, X_SAMPLE_OFS, 8'h00, a, q);
      check(q, 8'h2A);
      u_host.xfer(1'b0, Y_SAMPLE_OFS, 8'h00, a, q);
      check(q, 8'h15);
      u_host.xfer(1'b0, Z_SAMPLE_OFS, 8'h00, a, q);
      check(q, 8'h3F);
      check({7'h00, irq}, 8'h01);
      u_host.xfer(1'b0, STATUS_OFS, 8'h00, a, q);
      check(q, 8'h20);
      check({7'h00, irq}, 8'h00);
      $display("test mode done");
      // First Active interval starts at entry and loads the converter values
      u_host.xfer(1'b1, MODE_CONTROL_OFS, 8'h01, a, q);
      check({6'h00, mode}, {6'h00, MODE_ACTIVE});
      u_host.xfer(1'b0, X_SAMPLE_OFS, 8'h00, a, q);
      check(q, {2'h0, mx});
      u_host.xfer(1'b0, Y_SAMPLE_OFS, 8'h00, a, q);
      check(q, {2'h0, my});
      u_host.xfer(1'b0, Z_SAMPLE_OFS, 8'h00, a, q);
      check(q, {2'h0, mz});
      check({7'h00, meas_start}, 8'h00);
      u_host.xfer(1'b0, STATUS_OFS, 8'h00, a, q);
      check(q, 8'h20);
      u_host.xfer(1'b1, MODE_CONTROL_OFS, 8'h00, a, q);
      check({6'h00, mode}, {6'h00, MODE_STANDBY});
      // Auto-sleep with a zero count drops to sleep on the first sample
      u_host.xfer(1'b1, INTERRUPT_SETUP_OFS, 8'h18, a, q);
      u_host.xfer(1'b1, MODE_CONTROL_OFS, 8'h19, a, q);
      check({7'h00, a}, 8'h01);
      u_host.xfer(1'b0, STATUS_OFS, 8'h00, a, q);
      check(q, 8'hA2);
      check({7'h00, asleep}, 8'h01);
      check({7'h00, irq}, 8'h00);
      u_host.xfer(1'b1, MODE_CONTROL_OFS, 8'h00, a, q);
      check({6'h00, mode}, {6'h00, MODE_STANDBY});
      cyc(1);
      check({7'h00, asleep}, 8'h00);
      avdd_ok_in <= 1'b0;
      cyc(5);
      check({6'h00, mode}, {6'h00, MODE_OFF});
      $display("mode switching done");
      end_sim();
   end
endmodule : tb_top
